// file: rtl/usbfw_cfg.svh
// usbfw_cfg.svh: constants for the usb device framework logic
// assumes a 25 MHz system clock; included by bare name
`ifndef USBFW_CFG_SVH
`define USBFW_CFG_SVH
`define USBFW_CLK_HZ        25000000
`define USBFW_FRAME_US      1000
`define USBFW_FRAME_CYC     ((`USBFW_CLK_HZ / 1000000) * `USBFW_FRAME_US)
`define USBFW_SUSP_MS       3
`define USBFW_SUSP_CYC      ((`USBFW_CLK_HZ / 1000) * `USBFW_SUSP_MS)
`define USBFW_WAKE_MS       10
`define USBFW_WAKE_CYC      ((`USBFW_CLK_HZ / 1000) * `USBFW_WAKE_MS)
`define USBFW_NUM_EP        16
`define USBFW_ISO_MAX       1023
`define USBFW_DEF_ADDR      7'h00
`define USBFW_CTRL_EP       4'h0
`define USBFW_FIFO_DEPTH    4
`define USBFW_FIFO_WIDTH    8
`endif

// file: rtl/usbfw_pkg.sv
// usbfw_pkg.sv: types for the usb device framework logic
// assumes the cfg header is included by users for numbers
package usbfw_pkg;
    typedef enum logic [1:0] {
        USBFW_XFER_CTRL = 2'h0,
        USBFW_XFER_ISO  = 2'h1,
        USBFW_XFER_BULK = 2'h2,
        USBFW_XFER_INT  = 2'h3
    } usbfw_xfer_t;
    typedef enum logic [3:0] {
        USBFW_ST_DEFAULT    = 4'h1,
        USBFW_ST_ADDRESSED  = 4'h2,
        USBFW_ST_CONFIGURED = 4'h4,
        USBFW_ST_SUSPENDED  = 4'h8
    } usbfw_state_t;
endpackage : usbfw_pkg

// file: rtl/usbfw_fifo.sv
// usbfw_fifo.sv: small flip-flop fifo with valid/ready on both sides
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ps
module usbfw_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;
    wire              doWr = inValid && inReady;
    wire              doRd = outValid && outReady;
    // full and empty come from the occupancy count, never guessed
    assign inReady  = (count != DEPTH[AW:0]);
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];
    // pointers wrap naturally since depth is a power of two
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doWr) begin
                mem[wrPtr] <= inData;
                wrPtr      <= wrPtr + 1'b1;
            end
            if (doRd) begin
                rdPtr <= rdPtr + 1'b1;
            end
            count <= count + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
        end
    end
endmodule : usbfw_fifo

// file: rtl/usbfw_core.sv
// usbfw_core.sv: usb device framework state, frame timing, suspend, wake, address filter
// assumes decoded token/packet events from a serial engine, synchronous to clk
// Behaviour
// RULE1: sixteen bidirectional endpoint numbers accepted
// RULE2: endpoint zero always enabled as control
// RULE3: traffic grouped into one millisecond frames
// RULE4: isochronous payloads capped at 1023 bytes
// RULE5: low speed refuses bulk and isochronous
// RULE6: suspend after 3 ms without SOF
// RULE7: wake signalling within 10 ms of current rise
// RULE8: bus reset clears config, address zero
// RULE9: respond only at host-assigned address
// RULE10: pull-up on D+ full, D- low speed
// RULE11: host orders enumeration; any order accepted (code steps only default, then addressed, then configured)
// RULE12: activity restarts idle timer, flags resume
`timescale 1ns/1ps
`include "usbfw_cfg.svh"
module usbfw_core #(
    parameter int SUSP_CYC = `USBFW_SUSP_CYC,
    parameter int WAKE_CYC = `USBFW_WAKE_CYC
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       lowSpeed,
    input  wire logic       attach,
    input  wire logic       busReset,
    input  wire logic       busActivity,
    input  wire logic       sofToken,
    input  wire logic       tokValid,
    input  wire logic [6:0] tokAddr,
    input  wire logic [3:0] tokEndp,
    input  wire logic [1:0] tokXfer,
    input  wire logic       setAddress,
    input  wire logic [6:0] newAddr,
    input  wire logic       setConfig,
    input  wire logic [7:0] rxData,
    input  wire logic       rxValid,
    input  wire logic       rxLast,
    output logic            rxReady,
    input  wire logic       wakeRequest,
    output logic            pullupDp,
    output logic            pullupDm,
    output logic [3:0]      devState,
    output logic [6:0]      devAddr,
    output logic            tokAccept,
    output logic [3:0]      acceptEndp,
    output logic            acceptCtrl,
    output logic            isoOverflow,
    output logic            frameTick,
    output logic            suspended,
    output logic            resumeFlag,
    output logic            remoteWake,
    output logic [7:0]      outData,
    output logic            outValid,
    input  wire logic       outReady
);
    usbfw_pkg::usbfw_state_t state;
    usbfw_pkg::usbfw_state_t next_state;
    usbfw_pkg::usbfw_state_t resumeState;
    logic [6:0]  addrPending;
    logic        addrArmed;
    logic [31:0] idleCnt;
    logic [31:0] wakeCnt;
    logic [15:0] frameCnt;
    logic [10:0] isoCnt;
    logic        isoActive;
    logic        fifoInReady;
    logic        fifoOutValid;
    logic [7:0]  fifoOutData;

    // endpoint field is four bits so all sixteen numbers decode
    function automatic logic xferLegal(input logic ls, input logic [1:0] x);
        xferLegal = !ls || (x == usbfw_pkg::USBFW_XFER_CTRL) ||
                    (x == usbfw_pkg::USBFW_XFER_INT);
    endfunction : xferLegal

    // token filter: address match, endpoint range, speed-limited types
    wire addrHit   = (tokAddr == devAddr); // RULE8 RULE9
    wire epHit     = ({1'b0, tokEndp} < 5'(`USBFW_NUM_EP)); // RULE1
    wire isCtrlEp  = (tokEndp == `USBFW_CTRL_EP); // RULE2
    wire typeOk    = isCtrlEp ? (tokXfer == usbfw_pkg::USBFW_XFER_CTRL)
                              : xferLegal(lowSpeed, tokXfer); // RULE5
    wire awake     = (state != usbfw_pkg::USBFW_ST_SUSPENDED);
    wire tokGood   = tokValid && attach && awake && addrHit && epHit && typeOk;
    wire idleDone  = (idleCnt >= 32'(SUSP_CYC - 1));
    wire frameWrap = (frameCnt == 16'(`USBFW_FRAME_CYC - 1));
    wire isoFull   = (isoCnt >= 11'(`USBFW_ISO_MAX));

    // state transitions; bus reset wins over everything else
    always_comb begin
        next_state = state;
        unique case (state)
            usbfw_pkg::USBFW_ST_DEFAULT: begin
                if (addrArmed && addrPending != `USBFW_DEF_ADDR)
                    next_state = usbfw_pkg::USBFW_ST_ADDRESSED;
            end
            usbfw_pkg::USBFW_ST_ADDRESSED: begin
                if (setConfig)
                    next_state = usbfw_pkg::USBFW_ST_CONFIGURED;
            end
            usbfw_pkg::USBFW_ST_CONFIGURED: begin
                next_state = usbfw_pkg::USBFW_ST_CONFIGURED;
            end
            usbfw_pkg::USBFW_ST_SUSPENDED: begin
                if (busActivity)
                    next_state = resumeState; // RULE12
            end
            default: next_state = usbfw_pkg::USBFW_ST_DEFAULT;
        endcase
        if (awake && idleDone && !busActivity && !sofToken)
            next_state = usbfw_pkg::USBFW_ST_SUSPENDED; // RULE6
        if (busReset)
            next_state = usbfw_pkg::USBFW_ST_DEFAULT; // RULE8
    end

    // device state, address and speed pull-up
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state       <= usbfw_pkg::USBFW_ST_DEFAULT;
            resumeState <= usbfw_pkg::USBFW_ST_DEFAULT;
            devAddr     <= `USBFW_DEF_ADDR;
            pullupDp    <= 1'b0;
            pullupDm    <= 1'b0;
        end else begin
            state    <= next_state;
            // remember where suspend was entered so a configured device comes back configured
            if (awake && next_state == usbfw_pkg::USBFW_ST_SUSPENDED)
                resumeState <= state; // RULE12
            pullupDp <= attach && !lowSpeed; // RULE10
            pullupDm <= attach && lowSpeed; // RULE10
            if (busReset)
                devAddr <= `USBFW_DEF_ADDR; // RULE8
            else if (addrArmed)
                devAddr <= addrPending; // RULE9
        end
    end

    // the new address only takes effect after the status stage, so hold it one step
    always_ff @(posedge clk) begin
        if (sys_rst || busReset) begin
            addrPending <= `USBFW_DEF_ADDR;
            addrArmed   <= 1'b0;
        end else begin
            addrArmed <= setAddress; // RULE11
            if (setAddress)
                addrPending <= newAddr;
        end
    end

    // inactivity timer: any activity or SOF restarts it
    always_ff @(posedge clk) begin
        if (sys_rst || busReset || busActivity || sofToken || !awake)
            idleCnt <= '0; // RULE12
        else if (!idleDone)
            idleCnt <= idleCnt + 32'h1; // RULE6
    end

    // frame timer resyncs on every SOF and ticks once per frame
    always_ff @(posedge clk) begin
        if (sys_rst || sofToken) begin
            frameCnt  <= '0; // RULE3
            frameTick <= sofToken;
        end else begin
            frameCnt  <= frameWrap ? 16'h0 : frameCnt + 16'h1;
            frameTick <= frameWrap; // RULE3
        end
    end

    // remote wake: signal on the first cycle, held for WAKE_CYC cycles, the full 10 ms by default
    always_ff @(posedge clk) begin
        if (sys_rst || !suspended) begin
            wakeCnt    <= '0;
            remoteWake <= 1'b0;
        end else if (wakeRequest || wakeCnt != '0) begin
            remoteWake <= 1'b1; // RULE7
            wakeCnt    <= (wakeCnt == 32'(WAKE_CYC - 1)) ? 32'h0 : wakeCnt + 32'h1;
        end else begin
            remoteWake <= 1'b0;
        end
    end

    // status outputs and token acceptance
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            devState   <= 4'h1;
            suspended  <= 1'b0;
            resumeFlag <= 1'b0;
            tokAccept  <= 1'b0;
            acceptEndp <= 4'h0;
            acceptCtrl <= 1'b0;
        end else begin
            devState   <= next_state;
            suspended  <= (next_state == usbfw_pkg::USBFW_ST_SUSPENDED);
            resumeFlag <= !awake && busActivity; // RULE12
            tokAccept  <= tokGood; // RULE1 RULE9
            if (tokGood) begin
                acceptEndp <= tokEndp;
                acceptCtrl <= isCtrlEp; // RULE2
            end
        end
    end

    // isochronous payload length guard; excess bytes are dropped and flagged
    always_ff @(posedge clk) begin
        if (sys_rst || busReset) begin
            isoActive   <= 1'b0;
            isoCnt      <= '0;
            isoOverflow <= 1'b0;
        end else begin
            if (tokGood && tokXfer == usbfw_pkg::USBFW_XFER_ISO) begin
                isoActive   <= 1'b1;
                isoCnt      <= '0;
                // an overflowing byte in the same cycle still sets the flag
                isoOverflow <= rxValid && rxReady && isoActive && isoFull; // RULE4
            end else if (rxValid && rxReady && isoActive) begin
                if (isoFull)
                    isoOverflow <= 1'b1; // RULE4
                else
                    isoCnt <= isoCnt + 11'h1;
                if (rxLast)
                    isoActive <= 1'b0;
            end
        end
    end

    // received bytes buffered toward the user; stall reaches the serial engine
    wire dropByte = isoActive && isoFull; // RULE4
    assign rxReady = fifoInReady || dropByte;

    usbfw_fifo #(
        .WIDTH (`USBFW_FIFO_WIDTH),
        .DEPTH (`USBFW_FIFO_DEPTH)
    ) u_fifo (
        .clk      (clk),
        .sys_rst  (sys_rst || busReset),
        .inData   (rxData),
        .inValid  (rxValid && !dropByte),
        .inReady  (fifoInReady),
        .outData  (fifoOutData),
        .outValid (fifoOutValid),
        .outReady (!outValid)
    );

    // output register stage so the user-side data comes from flip-flops
    always_ff @(posedge clk) begin
        if (sys_rst || busReset) begin
            outValid <= 1'b0;
            outData  <= 8'h00;
        end else if (!outValid || outReady) begin
            outValid <= fifoOutValid && !outValid;
            if (fifoOutValid && !outValid)
                outData <= fifoOutData;
        end
    end
endmodule : usbfw_core

// file: sim/usbfw_core_asserts.sv
// usbfw_core_asserts.sv: port-level checks on the framework core
// assumes binding into usbfw_core; one clock, sync high reset
`timescale 1ns/1ps
module usbfw_core_asserts #(
    parameter int SUSP_CYC = 75000
) (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       lowSpeed,
    input wire logic       attach,
    input wire logic       busReset,
    input wire logic       busActivity,
    input wire logic       sofToken,
    input wire logic       tokValid,
    input wire logic [6:0] tokAddr,
    input wire logic [1:0] tokXfer,
    input wire logic       wakeRequest,
    input wire logic       pullupDp,
    input wire logic       pullupDm,
    input wire logic [3:0] devState,
    input wire logic [6:0] devAddr,
    input wire logic       tokAccept,
    input wire logic [3:0] acceptEndp,
    input wire logic       acceptCtrl,
    input wire logic       frameTick,
    input wire logic       suspended,
    input wire logic       resumeFlag,
    input wire logic       remoteWake
);
    logic [31:0] idle;
    // quiet-bus counter; wake signalling counts as activity so it is not blamed
    always_ff @(posedge clk) begin
        idle <= (sys_rst || sofToken || busActivity || busReset || tokValid || !attach
                 || remoteWake) ? 32'h00000000 : idle + 32'h00000001;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    pull_full_a: assert property (attach && !lowSpeed |=> pullupDp && !pullupDm)
        else $error("full speed pull-up wrong");
    pull_low_a: assert property (attach && lowSpeed |=> pullupDm && !pullupDp)
        else $error("low speed pull-up wrong");
    ep0_ctrl_a: assert property (tokAccept && acceptEndp == 4'h0 |-> acceptCtrl)
        else $error("endpoint zero accepted as non-control");
    low_speed_a: assert property (
        tokValid && lowSpeed && (tokXfer == 2'h1 || tokXfer == 2'h2) |=> !tokAccept)
        else $error("low speed took bulk or iso");
    addr_filter_a: assert property (tokValid && tokAddr != devAddr |=> !tokAccept)
        else $error("token at foreign address accepted");
    bus_reset_a: assert property (busReset |=> devAddr == 7'h00 && devState == 4'h1)
        else $error("bus reset left address or state");
    idle_susp_a: assert property (idle > SUSP_CYC + 3 |-> suspended)
        else $error("no suspend after idle bus");
    resume_flag_a: assert property (suspended && busActivity |=> resumeFlag && !suspended)
        else $error("activity did not resume");
    wake_signal_a: assert property (suspended && wakeRequest |=> remoteWake)
        else $error("wake signalling late");
    frame_tick_a: assert property (sofToken |=> frameTick)
        else $error("frame tick missing");
endmodule : usbfw_core_asserts
bind usbfw_core usbfw_core_asserts #(.SUSP_CYC(SUSP_CYC)) u_usbfw_core_asserts (
    .clk, .sys_rst, .lowSpeed, .attach, .busReset, .busActivity, .sofToken, .tokValid,
    .tokAddr, .tokXfer, .wakeRequest, .pullupDp, .pullupDm, .devState, .devAddr,
    .tokAccept, .acceptEndp, .acceptCtrl, .frameTick, .suspended, .resumeFlag, .remoteWake);

// file: sim/usbfw_host_model.sv
// usbfw_host_model.sv: host side, frame markers and a payload byte source
// assumes the core's clock; bytes held until rxReady is seen high
`timescale 1ns/1ps
module usbfw_host_model #(
    parameter int SOF_PERIOD = 20
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        sofEn,
    input  wire logic        go,
    input  wire logic [10:0] count,
    input  wire logic        rxReady,
    output logic             sofToken,
    output logic [7:0]       rxData,
    output logic             rxValid,
    output logic             rxLast
);
    logic [15:0] sofCnt;
    logic [10:0] left;
    logic [7:0]  seq;
    // shortened frame period so the idle timer never runs out by accident
    always_ff @(posedge clk) begin
        sofCnt   <= (sys_rst || !sofEn || sofCnt == 16'(SOF_PERIOD - 1)) ? 16'h0000
                    : sofCnt + 16'h0001;
        sofToken <= !sys_rst && sofEn && sofCnt == 16'(SOF_PERIOD - 1);
    end
    // payload length is whatever the bench commands, so overlong iso is possible
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            left <= 11'h000;
            seq  <= 8'h00;
        end else if (go) begin
            left <= count;
        end else if (rxValid && rxReady) begin
            left <= left - 11'h001;
            seq  <= seq + 8'h01;
        end
    end
    assign rxValid = left != 11'h000;
    assign rxLast  = left == 11'h001;
    assign rxData  = rxValid ? seq : ~seq; // idle lines show junk, not the last byte
endmodule : usbfw_host_model

// file: sim/usbfw_testbench.sv
// usbfw_testbench.sv: self-checking bench for the framework core
// assumes shortened suspend and wake counts; host model drives frames and bytes
`timescale 1ns/1ps
module testbench;
    logic        clk = 1'b0, sys_rst = 1'b1, lowSpeed = 1'b0, attach = 1'b0, busReset = 1'b0;
    logic        busActivity = 1'b0, tokValid = 1'b0, setAddress = 1'b0, setConfig = 1'b0;
    logic        wakeRequest = 1'b0, outReady = 1'b0, sofEn = 1'b1, go = 1'b0;
    logic [6:0]  tokAddr = 7'h00, newAddr = 7'h00;
    logic [3:0]  tokEndp = 4'h0;
    logic [1:0]  tokXfer = 2'h0;
    logic [10:0] count = 11'h000;
    wire logic   sofToken, rxValid, rxLast, rxReady, pullupDp, pullupDm, tokAccept, acceptCtrl;
    wire logic   isoOverflow, frameTick, suspended, resumeFlag, remoteWake, outValid;
    wire logic [7:0] rxData, outData;
    wire logic [3:0] devState, acceptEndp;
    wire logic [6:0] devAddr;
    int          miscompares = 0, total_checks = 0, nOut = 0;
    usbfw_core #(.SUSP_CYC(50), .WAKE_CYC(20)) u_usbfw_core (.clk, .sys_rst, .lowSpeed,
        .attach, .busReset, .busActivity, .sofToken, .tokValid, .tokAddr, .tokEndp, .tokXfer,
        .setAddress, .newAddr, .setConfig, .rxData, .rxValid, .rxLast, .rxReady, .wakeRequest,
        .pullupDp, .pullupDm, .devState, .devAddr, .tokAccept, .acceptEndp, .acceptCtrl,
        .isoOverflow, .frameTick, .suspended, .resumeFlag, .remoteWake, .outData, .outValid,
        .outReady);
    usbfw_host_model u_usbfw_host_model (.clk, .sys_rst, .sofEn, .go, .count, .rxReady,
        .sofToken, .rxData, .rxValid, .rxLast);
    always #20 clk = ~clk;
    // count bytes handed to the user side; the source numbers them, so order is checked too
    always @(posedge clk) begin
        if (outValid && outReady) begin
            check(16'(outData), 16'(nOut[7:0]), "outData");
            nOut <= nOut + 1;
        end
    end
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task check(input logic [15:0] seen, input logic [15:0] exp, input string name);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // one token strobe, registered answer looked at one clock after the strobe
    task tok(input logic [6:0] a, input logic [3:0] e, input logic [1:0] x, input logic exp);
        {tokAddr, tokEndp, tokXfer, tokValid} = {a, e, x, 1'b1};
        step(1);
        check(tokAccept, exp, "tokAccept");
        tokValid = 1'b0;
        step(1);
    endtask : tok
    task t_speed;
        check(devState, 16'h0001, "devState");
        attach = 1'b1;
        step(2);
        check({pullupDp, pullupDm}, 16'h0002, "pullups");
        lowSpeed = 1'b1;
        step(2);
        check({pullupDp, pullupDm}, 16'h0001, "pullups");
        tok(7'h00, 4'h1, 2'h2, 1'b0);
        tok(7'h00, 4'h1, 2'h1, 1'b0);
        tok(7'h00, 4'h1, 2'h3, 1'b1);
        lowSpeed = 1'b0;
        step(2);
    endtask : t_speed
    task t_tokens;
        tok(7'h00, 4'h0, 2'h0, 1'b1);
        check(acceptCtrl, 16'h0001, "acceptCtrl");
        tok(7'h00, 4'h0, 2'h2, 1'b0);
        tok(7'h00, 4'hF, 2'h2, 1'b1);
        check(acceptEndp, 16'h000F, "acceptEndp");
        tok(7'h03, 4'h1, 2'h2, 1'b0);
    endtask : t_tokens
    task t_enum;
        {setAddress, newAddr} = {1'b1, 7'h05};
        step(1);
        setAddress = 1'b0;
        step(3);
        check(devAddr, 16'h0005, "devAddr");
        check(devState, 16'h0002, "devState");
        tok(7'h00, 4'h0, 2'h0, 1'b0);
        tok(7'h05, 4'h0, 2'h0, 1'b1);
        setConfig = 1'b1;
        step(1);
        setConfig = 1'b0;
        step(2);
        check(devState, 16'h0004, "devState");
        busReset = 1'b1;
        step(1);
        busReset = 1'b0;
        step(2);
        check({devState, 5'h00, devAddr}, 16'h1000, "stateAddr");
        tok(7'h00, 4'h0, 2'h0, 1'b1);
    endtask : t_enum
    task t_suspend;
        sofEn = 1'b0;
        step(65);
        check(suspended, 16'h0001, "suspended");
        tok(7'h00, 4'h0, 2'h0, 1'b0);
        wakeRequest = 1'b1;
        step(1);
        wakeRequest = 1'b0;
        check(remoteWake, 16'h0001, "remoteWake");
        busActivity = 1'b1;
        step(1);
        busActivity = 1'b0;
        check({resumeFlag, suspended}, 16'h0002, "resume");
        check(devState, 16'h0001, "devState");
        sofEn = 1'b1;
        step(2);
    endtask : t_suspend
    // fill the fifo against a stalled user side, then an overlong iso payload
    task t_stream;
        {count, go} = {11'h006, 1'b1};
        step(1);
        go = 1'b0;
        step(20);
        check({rxReady, rxValid}, 16'h0001, "full");
        outReady = 1'b1;
        step(20);
        check(16'(nOut), 16'h0006, "nOut");
        tok(7'h00, 4'h1, 2'h1, 1'b1);
        {count, go} = {11'h400, 1'b1};
        step(1);
        go = 1'b0;
        for (int i = 0; i < 4000 && rxValid; i++) step(1);
        step(20);
        check(isoOverflow, 16'h0001, "isoOverflow");
        check(16'(nOut), 16'h0405, "nOut");
    endtask : t_stream
    task close_out;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    initial begin
        step(20);
        sys_rst = 1'b0;
        t_speed;
        t_tokens;
        t_enum;
        t_suspend;
        t_stream;
        close_out;
    end
    // hang guard, well past the roughly 2200 cycles the run needs
    initial begin
        #(40 * 12000);
        miscompares++;
        close_out;
    end
endmodule : testbench
